// ### verilog/ocp_defines.vh
// Constants for the compare channel PWM block
`ifndef OCP_DEFINES_VH
`define OCP_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OCP_ADDR_CTRL 12'h000
`define OCP_ADDR_CTRL_CLR 12'h004
`define OCP_ADDR_CTRL_SET 12'h008
`define OCP_ADDR_DUTY 12'h010
`define OCP_ADDR_DUTY_BUF 12'h020
`define OCP_ADDR_TB_PERIOD 12'h030
`define OCP_ADDR_TB_COUNT 12'h040
`define OCP_ADDR_FLAGS 12'h050
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define OCP_CTRL_MODE_LSB 0
`define OCP_CTRL_MODE_MSB 2
`define OCP_CTRL_FAULT_BIT 4
`define OCP_CTRL_W32_BIT 5
`define OCP_CTRL_IDLE_STOP_BIT 13
`define OCP_CTRL_ON_BIT 15
`define OCP_CTRL_RUN_BIT 16
`define OCP_CTRL_FSEL_BIT 17
`define OCP_CTRL_WMASK 32'h0003A027
`define OCP_MODE_PWM 3'h6
`define OCP_MODE_PWM_FLT 3'h7
// ----------------------------------------
// Flag register fields
// ----------------------------------------
`define OCP_FLAG_PERIOD_BIT 0
`define OCP_FLAG_EVENT_BIT 1
`define OCP_FLAG_PERIOD_IE_BIT 8
`define OCP_FLAG_EVENT_IE_BIT 9
// ----------------------------------------
// Reset values
// ----------------------------------------
`define OCP_RST_PERIOD 32'h0000FFFF
`endif

// ### verilog/ocp_pwm.v
// Compare channel PWM generator with fault shutdown and APB registers
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ocp_defines.vh"

module ocp_pwm #(
   parameter CHANNEL = 1
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire fault_input_a,
   input wire fault_input_b,
   input wire sleep_req,
   input wire idle_req,
   output wire waveform_output_pin,
   output wire waveform_output_oe,
   output reg irq_q
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [31:0] ctrl_q;
   reg [31:0] duty_q;
   reg [31:0] duty_buf_q;
   reg [31:0] period_q;
   reg [31:0] count_q;
   reg period_flag_q;
   reg event_flag_q;
   reg period_ie_q;
   reg event_ie_q;
   reg fault_q;
   reg out_q;
   reg oe_q;
   reg flt_s1_q;
   reg flt_s2_q;
   reg slp_s1_q;
   reg slp_s2_q;
   reg idl_s1_q;
   reg idl_s2_q;

   // Truncate a value to its low 16 bits unless 32-bit timebase is selected
   function [31:0] width_sel;
      input [31:0] v;
      input w32;
      begin
         width_sel = w32 ? v : {16'h0000, v[15:0]};
      end
   endfunction

   wire fault_pin = (CHANNEL == 5) ? fault_input_b : fault_input_a;
   wire [2:0] mode = ctrl_q[`OCP_CTRL_MODE_MSB:`OCP_CTRL_MODE_LSB];
   wire w32 = ctrl_q[`OCP_CTRL_W32_BIT];
   wire on = ctrl_q[`OCP_CTRL_ON_BIT];
   wire pwm_mode = on && (mode == `OCP_MODE_PWM || mode == `OCP_MODE_PWM_FLT);
   wire flt_mode = pwm_mode && (mode == `OCP_MODE_PWM_FLT);
   // Halt in sleep, or in idle when idle-stop is set
   wire halted = slp_s2_q || (idl_s2_q && ctrl_q[`OCP_CTRL_IDLE_STOP_BIT]);
   wire running = pwm_mode && ctrl_q[`OCP_CTRL_RUN_BIT] && !halted;
   wire [31:0] cnt = width_sel(count_q, w32);
   wire [31:0] per = width_sel(period_q, w32);
   wire [31:0] dty = width_sel(duty_q, w32);
   wire period_match = running && (cnt == per);
   wire fault_det = flt_mode && !flt_s2_q;

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   // Raw pin gates the enable so shutdown needs no clock, also in sleep
   assign waveform_output_oe = oe_q && !(flt_mode && !fault_pin) && !fault_q;
   assign waveform_output_pin = out_q;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire acc = psel && penable && pready;
   wire wr = acc && pwrite;
   reg sel_ctrl;
   reg sel_clr;
   reg sel_set;
   reg sel_duty;
   reg sel_buf;
   reg sel_period;
   reg sel_flags;

   // Write decode; the count register is read-only and takes no strobe
   always @* begin
      sel_ctrl = 1'b0;
      sel_clr = 1'b0;
      sel_set = 1'b0;
      sel_duty = 1'b0;
      sel_buf = 1'b0;
      sel_period = 1'b0;
      sel_flags = 1'b0;
      if (paddr == `OCP_ADDR_CTRL) begin
         sel_ctrl = 1'b1;
      end else if (paddr == `OCP_ADDR_CTRL_CLR) begin
         sel_clr = 1'b1;
      end else if (paddr == `OCP_ADDR_CTRL_SET) begin
         sel_set = 1'b1;
      end else if (paddr == `OCP_ADDR_DUTY) begin
         sel_duty = 1'b1;
      end else if (paddr == `OCP_ADDR_DUTY_BUF) begin
         sel_buf = 1'b1;
      end else if (paddr == `OCP_ADDR_TB_PERIOD) begin
         sel_period = 1'b1;
      end else if (paddr == `OCP_ADDR_FLAGS) begin
         sel_flags = 1'b1;
      end
   end

   wire wr_ctrl = wr && sel_ctrl;
   wire wr_clr = wr && sel_clr;
   wire wr_set = wr && sel_set;
   wire [31:0] ctrl_wr = wr_ctrl ? pwdata :
                         wr_clr ? (ctrl_q & ~pwdata) : (ctrl_q | pwdata);
   wire ctrl_we = wr_ctrl || wr_clr || wr_set;
   // Rewriting the mode field (any write touching it) arms fault recovery
   wire mode_wr = wr_ctrl ||
                  ((wr_clr || wr_set) && |pwdata[`OCP_CTRL_MODE_MSB:`OCP_CTRL_MODE_LSB]);
   reg [31:0] rdata;
   reg known;

   always @* begin
      rdata = 32'h00000000;
      known = 1'b1;
      if (paddr == `OCP_ADDR_CTRL) begin
         rdata = (ctrl_q & `OCP_CTRL_WMASK) | ({31'h00000000, fault_q} << `OCP_CTRL_FAULT_BIT);
      end else if (paddr == `OCP_ADDR_CTRL_CLR || paddr == `OCP_ADDR_CTRL_SET) begin
         rdata = 32'h00000000;
      end else if (paddr == `OCP_ADDR_DUTY) begin
         rdata = duty_q;
      end else if (paddr == `OCP_ADDR_DUTY_BUF) begin
         rdata = duty_buf_q;
      end else if (paddr == `OCP_ADDR_TB_PERIOD) begin
         rdata = period_q;
      end else if (paddr == `OCP_ADDR_TB_COUNT) begin
         rdata = count_q;
      end else if (paddr == `OCP_ADDR_FLAGS) begin
         rdata = {22'h000000, event_ie_q, period_ie_q, 6'h00, event_flag_q, period_flag_q};
      end else begin
         known = 1'b0;
      end
   end

   // ----------------------------------------
   // Bus slave: no wait states, error on unmapped address
   // ----------------------------------------
   // Ready comes from the setup cycle alone, so every access takes two cycles
   wire setup_phase = psel && !penable;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup_phase;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup_phase && !known;
      end
   end

   // Read data is captured in setup and stands only while ready is high
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup_phase && !pwrite) begin
         prdata <= rdata;
      end else begin
         prdata <= 32'h00000000;
      end
   end

   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   // Fault stages reset high, the idle level of the pin, so no false fault follows reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flt_s1_q <= 1'b1;
         flt_s2_q <= 1'b1;
      end else begin
         flt_s1_q <= fault_pin;
         flt_s2_q <= flt_s1_q;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slp_s1_q <= 1'b0;
         slp_s2_q <= 1'b0;
      end else begin
         slp_s1_q <= sleep_req;
         slp_s2_q <= slp_s1_q;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idl_s1_q <= 1'b0;
         idl_s2_q <= 1'b0;
      end else begin
         idl_s1_q <= idle_req;
         idl_s2_q <= idl_s1_q;
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 32'h00000000;
      end else if (ctrl_we) begin
         ctrl_q <= ctrl_wr & `OCP_CTRL_WMASK;
      end
   end

   // ----------------------------------------
   // Duty buffer and active duty
   // ----------------------------------------
   wire buf_wr = wr && sel_buf;
   // Software may only load the active duty while PWM is off
   wire duty_wr = wr && sel_duty && !pwm_mode;
   wire period_wr = wr && sel_period;
   wire flag_wr = wr && sel_flags;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_buf_q <= 32'h00000000;
      end else if (buf_wr) begin
         duty_buf_q <= pwdata;
      end
   end

   // Reload only at the period match, so a buffer write never cuts a pulse short
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_q <= 32'h00000000;
      end else if (period_match) begin
         duty_q <= duty_buf_q;
      end else if (duty_wr) begin
         duty_q <= pwdata;
      end
   end

   // ----------------------------------------
   // Period and interrupt enables
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_q <= `OCP_RST_PERIOD;
      end else if (period_wr) begin
         period_q <= pwdata;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_ie_q <= 1'b0;
         event_ie_q <= 1'b0;
      end else if (flag_wr) begin
         period_ie_q <= pwdata[`OCP_FLAG_PERIOD_IE_BIT];
         event_ie_q <= pwdata[`OCP_FLAG_EVENT_IE_BIT];
      end
   end

   // ----------------------------------------
   // Timebase counter
   // ----------------------------------------
   // Counts 0 to period inclusive; halting freezes it, leaving PWM clears it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= 32'h00000000;
      end else if (!pwm_mode || !ctrl_q[`OCP_CTRL_RUN_BIT]) begin
         count_q <= 32'h00000000;
      end else if (period_match) begin
         count_q <= 32'h00000000;
      end else if (running) begin
         count_q <= width_sel(count_q + 32'h00000001, w32);
      end
   end

   // ----------------------------------------
   // Flags
   // ----------------------------------------
   // Write one to clear; an event in the same cycle wins over the clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_flag_q <= 1'b0;
      end else begin
         period_flag_q <= period_match ||
            (period_flag_q && !(flag_wr && pwdata[`OCP_FLAG_PERIOD_BIT]));
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_flag_q <= 1'b0;
      end else begin
         event_flag_q <= fault_det ||
            (event_flag_q && !(flag_wr && pwdata[`OCP_FLAG_EVENT_BIT]));
      end
   end

   // ----------------------------------------
   // Fault latch
   // ----------------------------------------
   // The latch needs one low sample through the synchroniser, so a fault pulse that
   // falls between two clock edges only cuts the pin while it lasts
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_q <= 1'b0;
      end else if (fault_det) begin
         fault_q <= 1'b1;
      end else if (mode_wr && flt_s2_q) begin
         fault_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Interrupt line
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (period_flag_q && period_ie_q) || (event_flag_q && event_ie_q);
      end
   end

   // ----------------------------------------
   // Waveform and output enable
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= pwm_mode;
      end
   end

   // Halting keeps the last level on the pin through sleep
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= 1'b0;
      end else if (!pwm_mode) begin
         out_q <= 1'b0;
      end else if (!halted) begin
         out_q <= (cnt < dty);
      end
   end
endmodule
`default_nettype wire

// ### tb/ocp_pwm_properties.sv
// Port assertions for the compare channel PWM block
`timescale 1ns/1ns
`default_nettype none
module ocp_pwm_properties #(
   parameter CHANNEL = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic fault_input_a,
   input wire logic fault_input_b,
   input wire logic sleep_req,
   input wire logic waveform_output_pin,
   input wire logic waveform_output_oe
);
   logic flt_n;
   assign flt_n = (CHANNEL == 5) ? fault_input_b : fault_input_a;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_after: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_ready_cause: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   chk_idle_quiet: assert property (!psel |=> !pready)
      else $error("ready without request");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   chk_sleep_hold: assert property (sleep_req [*4] |=> $stable(waveform_output_pin))
      else $error("pin moved in sleep");
   // Output may only come back once the fault pin is high again
   chk_oe_return: assert property ($rose(waveform_output_oe) |-> flt_n)
      else $error("output enabled during fault");
   cover property (pslverr);
   cover property ($fell(waveform_output_oe));
   cover property (sleep_req [*4]);
endmodule
bind ocp_pwm ocp_pwm_properties #(.CHANNEL(CHANNEL)) u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .fault_input_a(fault_input_a), .fault_input_b(fault_input_b),
   .sleep_req(sleep_req), .waveform_output_pin(waveform_output_pin),
   .waveform_output_oe(waveform_output_oe));
`default_nettype wire

// ### tb/ocp_load.sv
// External load with pull-down and fault source for the PWM pin
`timescale 1ns/1ns
`default_nettype none
module ocp_load (
   input wire logic pin,
   input wire logic oe,
   input wire logic fault_req,
   output logic pad,
   output logic fault_n
);
   // Pull-down gives a known level while the channel lets go of the pin
   assign pad = oe ? pin : 1'b0;
   // Active low, no relation to the bus clock
   assign fault_n = ~fault_req;
endmodule
`default_nettype wire

// ### tb/compare_channel_pwm_with_fault_tb.sv
// Self-checking testbench for the compare channel PWM block
`timescale 1ns/1ns
`default_nettype none
`include "ocp_defines.vh"
module compare_channel_pwm_with_fault_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fault_req = 0, sleep_req = 0;
   logic fault_b_n = 1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, pin, oe, irq_q, pad, fault_n, er;
   int err_total = 0, n_tests = 0, cyc = 0, p, d, h;
   ocp_pwm #(.CHANNEL(1)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fault_input_a(fault_n), .fault_input_b(fault_b_n),
      .sleep_req(sleep_req), .idle_req(1'b0), .waveform_output_pin(pin),
      .waveform_output_oe(oe), .irq_q(irq_q));
   ocp_load LOAD (.pin(pin), .oe(oe), .fault_req(fault_req), .pad(pad), .fault_n(fault_n));
   initial forever #2 pclk = ~pclk;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // ----------------------------------------
   // Bus master: holds the request until ready is sampled high
   // ----------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic int exp_hi(input int dd, input int pp);
      return (dd > pp) ? pp + 1 : dd;
   endfunction
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Run is far below this; reaching it means a hang
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         wrap_up;
      end
   end
   initial begin
      void'($urandom(58204));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `OCP_ADDR_TB_PERIOD, 0);
      chk("period reset", `OCP_RST_PERIOD, rd);
      apb(0, 12'hFFC, 0);
      chk("unmapped err", 1, er);
      $display("test bus done");
      p = 3 + $urandom % 6;
      // Upper half set: 16-bit timebase must ignore it
      apb(1, `OCP_ADDR_TB_PERIOD, 32'h00010000 | p);
      for (int k = 0; k < 4; k++) begin
         d = (k == 0) ? 0 : (k == 1) ? p : (k == 2) ? p + 1 : $urandom % (p + 1);
         apb(1, `OCP_ADDR_DUTY_BUF, d);
         apb(1, `OCP_ADDR_DUTY, d);
         apb(1, `OCP_ADDR_CTRL, 32'h00018006);
         repeat (2 * (p + 1)) @(posedge pclk);
         h = 0;
         repeat (4 * (p + 1)) begin
            @(posedge pclk);
            if (pad === 1'b1) h++;
         end
         chk("high count", 4 * exp_hi(d, p), h);
      end
      apb(1, `OCP_ADDR_DUTY, d + 1);
      apb(0, `OCP_ADDR_DUTY, 0);
      chk("duty locked", d, rd);
      apb(0, `OCP_ADDR_FLAGS, 0);
      chk("flags", 32'h1, rd & 32'h3);
      $display("test duty done");
      apb(1, `OCP_ADDR_FLAGS, 32'h00000203);
      apb(1, `OCP_ADDR_CTRL, 32'h00018007);
      chk("irq idle", 0, irq_q);
      @(posedge pclk);
      fault_req <= 1'b1;
      sleep_req <= 1'b1;
      #1 chk("oe fault", 0, oe);
      repeat (6) @(posedge pclk);
      chk("oe sleep", 0, oe);
      sleep_req <= 1'b0;
      fault_req <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("oe held", 0, oe);
      chk("irq event", 1, irq_q);
      apb(0, `OCP_ADDR_CTRL, 0);
      chk("fault bit", 1, rd[4]);
      apb(1, `OCP_ADDR_CTRL, 32'h00018007);
      repeat (4) @(posedge pclk);
      chk("oe back", 1, oe);
      apb(0, `OCP_ADDR_CTRL, 0);
      chk("fault clear", 0, rd[4]);
      fault_b_n <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("oe other fault pin", 1, oe);
      fault_b_n <= 1'b1;
      $display("test fault done");
      apb(1, `OCP_ADDR_CTRL, 32'h00018006);
      fault_req <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("oe no guard", 1, oe);
      fault_req <= 1'b0;
      $display("test plain mode done");
      // 32-bit timebase: a duty above 16 bits keeps the pin high at the start of the first period
      apb(1, `OCP_ADDR_CTRL, 32'h00000000);
      apb(1, `OCP_ADDR_DUTY, 32'h00010000);
      apb(1, `OCP_ADDR_CTRL, 32'h00018026);
      repeat (4) @(posedge pclk);
      chk("wide duty high", 1, pad);
      $display("test wide mode done");
      wrap_up;
   end
endmodule
`default_nettype wire
